//--- host_model.sv
// Host side of the register port: byte writes, byte reads and the unlock step.
// Assumes requests begin after reset is released, on the bank clock.
`include "pmic_cfg.svh"
`timescale 1ns/1ps
module host_model (
    input wire logic ref_clk,
    input wire logic [7:0] rd_data,
    output logic wr_en,
    output logic rd_en,
    output logic [7:0] sub_addr,
    output logic [7:0] wr_data
);
    // ====================
    // Bus cycles
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        sub_addr = 8'h00;
        wr_data = 8'h00;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        wr_en = 1'b1;
        sub_addr = a;
        wr_data = d;
        @(posedge ref_clk);
        #1;
        wr_en = 1'b0;
        // Released lines show the inverse, so a stale value never looks valid.
        sub_addr = ~a;
        wr_data = ~d;
    endtask : wr

    // The key depends on the target, so each protected write needs its own unlock.
    task automatic pwr(input logic [7:0] a, input logic [7:0] d);
        wr(`PWD_OFS, a ^ `UNLOCK_KEY);
        wr(a, d);
    endtask : pwr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        #1;
        rd_en = 1'b1;
        sub_addr = a;
        @(posedge ref_clk);
        #1;
        rd_en = 1'b0;
        sub_addr = ~a;
        d = rd_data;
    endtask : rd

    task automatic apply(input logic keep_charge);
        wr(`APPLY_OFS, keep_charge ? 8'h02 : 8'h01);
    endtask : apply
endmodule : host_model

//--- ms_timer.sv
// One-shot down counter; busy for count cycles from the start pulse on.
// Assumes a synchronous active-high reset; a new start restarts the count.
`timescale 1ns/1ps
module ms_timer import pmic_pkg::*; (
    input wire logic ref_clk,
    input wire logic reset,
    timer_if.timer tmr
);
    count_t left_ff;
    count_t nxt_left;

    always_comb begin
        nxt_left = left_ff;
        if (tmr.start) begin
            nxt_left = tmr.count - 32'h0000_0001;
        end else if (left_ff != 32'h0000_0000) begin
            nxt_left = left_ff - 32'h0000_0001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            left_ff <= 32'h0000_0000;
        end else begin
            left_ff <= nxt_left;
        end
    end

    assign tmr.busy = tmr.start | (left_ff != 32'h0000_0000);
endmodule : ms_timer

//--- pmic_cfg.svh
// Offsets, field positions, reset values and timing counts of the configuration bank.
// Assumes a 25 MHz clock and byte-wide register access.
`ifndef PMIC_CFG_SVH
`define PMIC_CFG_SVH

// ==========================================================================
// Register sub-addresses
`define PWD_OFS 8'h10
`define CFG1_OFS 8'h13
`define CFG2_OFS 8'h14
`define CFG3_OFS 8'h15
`define BUCK1_OFS 8'h16
`define APPLY_OFS 8'h1a

// ==========================================================================
// Reset values, writable and NVM-loaded masks, and the unlock key
`define CFG1_RST 8'h08
`define CFG2_RST 8'h40
`define CFG3_RST 8'h00
`define BUCK1_RST 8'h80
`define CFG1_MASK 8'hff
`define CFG2_MASK 8'hcf
`define CFG3_MASK 8'h3f
`define BUCK1_MASK 8'hbf
`define CFG2_NVM_MASK 8'hc0
`define BUCK1_NVM_MASK 8'h3f
`define UNLOCK_KEY 8'h5a

// ==========================================================================
// Field positions
`define F_TRST 7
`define F_BUF2 6
`define F_ROLE1 5
`define F_POWERGOOD_RISE_DELAY_LO 3
`define F_TIGHT 2
`define F_WARM 7
`define F_HYS 6
`define F_ILIM3_LO 2
`define F_PFO_LO 3
`define F_PFM 7
`define F_GO 0
`define F_APPLY_WITH_DISCHARGE_DISABLED 1

// ==========================================================================
// Times and cycle counts
`define CLK_HZ 25000000
`define CYC_PER_MS (`CLK_HZ / 1000)
`define HOLD_SHORT_S 8
`define HOLD_LONG_S 15
`define BLANK_MS 5
`define PGDLY0_MS 10
`define PGDLY1_MS 20
`define PGDLY2_MS 50
`define PGDLY3_MS 150
`define HOLD_SHORT_CYC (`HOLD_SHORT_S * `CLK_HZ)
`define HOLD_LONG_CYC (`HOLD_LONG_S * `CLK_HZ)
`define BLANK_CYC (`BLANK_MS * `CYC_PER_MS)
`define PGDLY0_CYC (`PGDLY0_MS * `CYC_PER_MS)
`define PGDLY1_CYC (`PGDLY1_MS * `CYC_PER_MS)
`define PGDLY2_CYC (`PGDLY2_MS * `CYC_PER_MS)
`define PGDLY3_CYC (`PGDLY3_MS * `CYC_PER_MS)

`endif

//--- pmic_config_register_bank.sv
// Configuration register bank with pin roles, power-good delay and buck one apply.
// Assumes a byte access port from the serial engine, synchronous to ref_clk.
`include "pmic_cfg.svh"
`timescale 1ns/1ps

module pmic_config_register_bank import pmic_pkg::*; #(
    parameter int HOLD_SHORT = `HOLD_SHORT_CYC,
    parameter int HOLD_LONG = `HOLD_LONG_CYC,
    parameter int BLANK = `BLANK_CYC,
    parameter int PGDLY0 = `PGDLY0_CYC,
    parameter int PGDLY1 = `PGDLY1_CYC,
    parameter int PGDLY2 = `PGDLY2_CYC,
    parameter int PGDLY3 = `PGDLY3_CYC
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] sub_addr,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data,
    input wire logic nvm_valid,
    input wire logic [7:0] nvm_reset_pin_powergood_undervoltage_lockout_threshold_config,
    input wire logic [7:0] nvm_supervisor_and_loadswitch_limit_config,
    input wire logic [7:0] nvm_buck_one,
    input wire logic button_pressed,
    output logic button_reset,
    input wire logic rails_good,
    output logic power_good,
    output logic monitor_blank,
    output logic [5:0] buck_one_code,
    output logic buck_one_pfm,
    output logic apply_no_discharge,
    output logic supervisor_tight_limits,
    output logic overvoltage_monitor_en,
    output logic [1:0] undervoltage_lockout_threshold,
    output logic lockout_hysteresis_sel,
    output logic [1:0] switch_three_current_limit,
    output logic [1:0] switch_two_current_limit,
    input wire logic powerfail_comparator_out,
    input wire logic [2:0] switch_enable,
    output logic [2:0] switch_on,
    output logic [2:0] switch_discharge,
    input wire logic first_out_ctrl,
    input wire logic second_out_ctrl,
    input wire logic third_out_ctrl,
    input wire logic first_io_pin_in,
    output logic first_io_pin_out,
    output logic first_io_pin_oe,
    output logic second_output_pin_out,
    output logic second_output_pin_oe,
    input wire logic third_io_pin_in,
    output logic third_io_pin_out,
    output logic third_io_pin_oe,
    output logic warm_reset_req
);
    // ======================================================================
    // Register file and unlock
    logic [7:0] cfg1_ff, cfg2_ff, cfg3_ff, buck_ff, rd_data_ff;
    logic [7:0] nxt_cfg1, nxt_cfg2, nxt_cfg3, nxt_buck, nxt_rd_data;
    logic [7:0] armed_addr_ff, nxt_armed_addr;
    logic armed_ff, nxt_armed;
    logic [5:0] applied_ff, nxt_applied;
    logic nodis_ff, nxt_nodis;
    logic protected_hit, unlock_ok, buck_write, go_hit;

    assign protected_hit = (sub_addr == `CFG1_OFS) || (sub_addr == `CFG2_OFS) ||
                           (sub_addr == `CFG3_OFS) || (sub_addr == `BUCK1_OFS);
    assign unlock_ok = armed_ff && (armed_addr_ff == sub_addr);
    assign buck_write = wr_en && (sub_addr == `BUCK1_OFS) && unlock_ok;
    assign go_hit = wr_en && (sub_addr == `APPLY_OFS) &&
                    (wr_data[`F_GO] || wr_data[`F_APPLY_WITH_DISCHARGE_DISABLED]);

    always_comb begin
        nxt_cfg1 = cfg1_ff;
        nxt_cfg2 = cfg2_ff;
        nxt_cfg3 = cfg3_ff;
        nxt_buck = buck_ff;
        nxt_armed = armed_ff;
        nxt_armed_addr = armed_addr_ff;
        nxt_applied = applied_ff;
        nxt_nodis = nodis_ff;
        nxt_rd_data = rd_data_ff;
        if (wr_en) begin
            // Any write consumes the unlock, so one key opens one write.
            nxt_armed = 1'b0;
            if (sub_addr == `PWD_OFS) begin
                nxt_armed = 1'b1;
                nxt_armed_addr = wr_data ^ `UNLOCK_KEY;
            end else if (protected_hit && unlock_ok) begin
                if (sub_addr == `CFG1_OFS) begin
                    nxt_cfg1 = wr_data & `CFG1_MASK;
                end else if (sub_addr == `CFG2_OFS) begin
                    nxt_cfg2 = wr_data & `CFG2_MASK;
                end else if (sub_addr == `CFG3_OFS) begin
                    nxt_cfg3 = wr_data & `CFG3_MASK;
                end else begin
                    nxt_buck = wr_data & `BUCK1_MASK;
                end
            end
        end
        if (go_hit) begin
            // Only the trigger moves the code onto the converter.
            nxt_applied = buck_ff[5:0];
            nxt_nodis = wr_data[`F_APPLY_WITH_DISCHARGE_DISABLED];
        end
        if (rd_en) begin
            if (sub_addr == `CFG1_OFS) begin
                nxt_rd_data = cfg1_ff;
            end else if (sub_addr == `CFG2_OFS) begin
                nxt_rd_data = cfg2_ff;
            end else if (sub_addr == `CFG3_OFS) begin
                nxt_rd_data = cfg3_ff;
            end else if (sub_addr == `BUCK1_OFS) begin
                nxt_rd_data = buck_ff;
            end else begin
                nxt_rd_data = 8'h00;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cfg1_ff <= nvm_valid ? nvm_reset_pin_powergood_undervoltage_lockout_threshold_config : `CFG1_RST;
            cfg2_ff <= nvm_valid ? ((nvm_supervisor_and_loadswitch_limit_config & `CFG2_NVM_MASK) |
                       (`CFG2_RST & ~`CFG2_NVM_MASK)) : `CFG2_RST;
            cfg3_ff <= `CFG3_RST;
            buck_ff <= nvm_valid ? ((nvm_buck_one & `BUCK1_NVM_MASK) |
                       (`BUCK1_RST & ~`BUCK1_NVM_MASK)) : `BUCK1_RST;
            applied_ff <= nvm_valid ? nvm_buck_one[5:0] : 6'(`BUCK1_RST & 8'h3f);
            nodis_ff <= 1'b0;
            armed_ff <= 1'b0;
            armed_addr_ff <= 8'h00;
            rd_data_ff <= 8'h00;
        end else begin
            cfg1_ff <= nxt_cfg1;
            cfg2_ff <= nxt_cfg2;
            cfg3_ff <= nxt_cfg3;
            buck_ff <= nxt_buck;
            applied_ff <= nxt_applied;
            nodis_ff <= nxt_nodis;
            armed_ff <= nxt_armed;
            armed_addr_ff <= nxt_armed_addr;
            rd_data_ff <= nxt_rd_data;
        end
    end

    assign rd_data = rd_data_ff;
    assign buck_one_code = applied_ff;
    assign buck_one_pfm = buck_ff[`F_PFM];
    assign apply_no_discharge = nodis_ff;
    assign supervisor_tight_limits = cfg1_ff[`F_TIGHT];
    assign overvoltage_monitor_en = cfg1_ff[`F_TIGHT];
    assign undervoltage_lockout_threshold = cfg1_ff[1:0];
    assign lockout_hysteresis_sel = cfg2_ff[`F_HYS];
    assign switch_three_current_limit = cfg2_ff[`F_ILIM3_LO +: 2];
    assign switch_two_current_limit = cfg2_ff[1:0];

    // ======================================================================
    // Monitor blanking and power-good delay
    timer_if blank_tmr ();
    timer_if pg_tmr ();
    pg_state_t pg_ff, nxt_pg;
    count_t pg_delay;

    assign blank_tmr.start = buck_write;
    assign blank_tmr.count = BLANK;
    assign monitor_blank = blank_tmr.busy;
    ms_timer blank_timer (.ref_clk(ref_clk), .reset(reset), .tmr(blank_tmr));
    ms_timer pg_timer (.ref_clk(ref_clk), .reset(reset), .tmr(pg_tmr));

    always_comb begin
        case (cfg1_ff[`F_POWERGOOD_RISE_DELAY_LO +: 2])
            2'b00: pg_delay = PGDLY0;
            2'b01: pg_delay = PGDLY1;
            2'b10: pg_delay = PGDLY2;
            default: pg_delay = PGDLY3;
        endcase
    end

    // The start is kept out of the state process, which reads the timer's busy flag back.
    assign pg_tmr.start = (pg_ff == PG_LOW) && rails_good;
    assign pg_tmr.count = pg_delay;

    always_comb begin
        nxt_pg = pg_ff;
        case (pg_ff)
            PG_LOW: begin
                if (rails_good) begin
                    nxt_pg = PG_WAIT;
                end
            end
            PG_WAIT: begin
                if (!rails_good) begin
                    nxt_pg = PG_LOW;
                end else if (!pg_tmr.busy) begin
                    nxt_pg = PG_HIGH;
                end
            end
            default: begin
                // A fault drops power-good at once; no delay on the way down.
                if (!rails_good) begin
                    nxt_pg = PG_LOW;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pg_ff <= PG_LOW;
        end else begin
            pg_ff <= nxt_pg;
        end
    end

    assign power_good = (pg_ff == PG_HIGH);

    // ======================================================================
    // Push-button hold timer
    count_t hold_ff, nxt_hold;
    logic btn_rst_ff, nxt_btn_rst;
    count_t hold_limit;

    assign hold_limit = cfg1_ff[`F_TRST] ? HOLD_LONG : HOLD_SHORT;

    always_comb begin
        nxt_hold = hold_ff;
        nxt_btn_rst = 1'b0;
        if (!button_pressed) begin
            nxt_hold = 32'h0000_0000;
        end else if (hold_ff != hold_limit) begin
            nxt_hold = hold_ff + 32'h0000_0001;
            nxt_btn_rst = (nxt_hold == hold_limit);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            hold_ff <= 32'h0000_0000;
            btn_rst_ff <= 1'b0;
        end else begin
            hold_ff <= nxt_hold;
            btn_rst_ff <= nxt_btn_rst;
        end
    end

    assign button_reset = btn_rst_ff;

    // ======================================================================
    // Load switches and pins
    logic [2:0] sw_on_ff, nxt_sw_on, sw_dis_ff, nxt_sw_dis;
    logic [5:0] pin_ff, nxt_pin;
    logic warm_ff, nxt_warm;
    logic second_src;

    always_comb begin
        // A comparator trip overrides software enables for flagged switches.
        nxt_sw_on = switch_enable & ~(cfg3_ff[`F_PFO_LO +: 3] &
                    {3{~powerfail_comparator_out}});
        nxt_sw_dis = cfg3_ff[2:0] & ~nxt_sw_on;
        second_src = cfg1_ff[`F_ROLE1] ? first_io_pin_in : second_out_ctrl;
        nxt_pin[0] = 1'b0;
        nxt_pin[1] = ~cfg1_ff[`F_ROLE1] & ~first_out_ctrl;
        nxt_pin[2] = cfg1_ff[`F_BUF2] & second_src;
        nxt_pin[3] = cfg1_ff[`F_BUF2] | ~second_src;
        nxt_pin[4] = 1'b0;
        nxt_pin[5] = ~cfg2_ff[`F_WARM] & ~third_out_ctrl;
        nxt_warm = cfg2_ff[`F_WARM] & ~third_io_pin_in;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sw_on_ff <= 3'h0;
            sw_dis_ff <= 3'h0;
            pin_ff <= 6'h00;
            warm_ff <= 1'b0;
        end else begin
            sw_on_ff <= nxt_sw_on;
            sw_dis_ff <= nxt_sw_dis;
            pin_ff <= nxt_pin;
            warm_ff <= nxt_warm;
        end
    end

    assign switch_on = sw_on_ff;
    assign switch_discharge = sw_dis_ff;
    assign first_io_pin_out = pin_ff[0];
    assign first_io_pin_oe = pin_ff[1];
    assign second_output_pin_out = pin_ff[2];
    assign second_output_pin_oe = pin_ff[3];
    assign third_io_pin_out = pin_ff[4];
    assign third_io_pin_oe = pin_ff[5];
    assign warm_reset_req = warm_ff;

    // ======================================================================
    // Checks
    a_pwd_reads_zero: assert property (@(posedge ref_clk) disable iff (reset)
        rd_en && sub_addr == `PWD_OFS |=> rd_data == 8'h00)
        else $error("password register read back nonzero");
    a_reserved_bits_zero: assert property (@(posedge ref_clk) disable iff (reset)
        rd_en && sub_addr == `CFG2_OFS |=> rd_data[5:4] == 2'b00)
        else $error("reserved bits read nonzero");
    a_locked_write_ignored: assert property (@(posedge ref_clk) disable iff (reset)
        wr_en && protected_hit && !unlock_ok |=> $stable({cfg1_ff, cfg2_ff, cfg3_ff, buck_ff}))
        else $error("locked write changed a register");
    a_blank_after_write: assert property (@(posedge ref_clk) disable iff (reset)
        buck_write |=> monitor_blank [*3])
        else $error("monitoring not blanked after buck write");
    a_apply_needs_go: assert property (@(posedge ref_clk) disable iff (reset)
        !$stable(buck_one_code) |-> $past(go_hit))
        else $error("buck code changed without trigger");
    a_pg_fall_fast: assert property (@(posedge ref_clk) disable iff (reset)
        power_good && !rails_good |=> !power_good)
        else $error("power-good fall was delayed");
    a_pg_rise_delay: assert property (@(posedge ref_clk) disable iff (reset)
        pg_ff == PG_LOW && rails_good |=> !power_good [*2])
        else $error("power-good rose without delay");
    a_powerfail_off: assert property (@(posedge ref_clk) disable iff (reset)
        cfg3_ff[`F_PFO_LO] && !powerfail_comparator_out |=> !switch_on[0])
        else $error("switch one on during power fail");
    a_discharge_when_off: assert property (@(posedge ref_clk) disable iff (reset)
        switch_discharge[2] |-> !switch_on[2] && $past(cfg3_ff[2]))
        else $error("discharge while switch on or disabled");
    a_warm_ignores_ctrl: assert property (@(posedge ref_clk) disable iff (reset)
        cfg2_ff[`F_WARM] |=> !third_io_pin_oe)
        else $error("third pin driven in warm-reset mode");
endmodule : pmic_config_register_bank

//--- pmic_config_register_bank_tb_top.sv
// Self-checking bench for the configuration bank, with shortened counts.
// Assumes the host model drives the register port and the bench drives the rest.
`include "pmic_cfg.svh"
`timescale 1ns/1ps
module pmic_config_register_bank_tb_top;
    logic ref_clk, reset, nvm_valid, button_pressed, rails_good, powerfail_comparator_out;
    logic first_out_ctrl, second_out_ctrl, third_out_ctrl, first_io_pin_in, third_io_pin_in;
    logic wr_en, rd_en, button_reset, power_good, monitor_blank, buck_one_pfm;
    logic apply_no_discharge, supervisor_tight_limits, overvoltage_monitor_en;
    logic lockout_hysteresis_sel, first_io_pin_out, first_io_pin_oe, second_output_pin_out;
    logic second_output_pin_oe, third_io_pin_out, third_io_pin_oe, warm_reset_req;
    logic [7:0] sub_addr, wr_data, rd_data, nvm_reset_pin_powergood_undervoltage_lockout_threshold_config, nvm_supervisor_and_loadswitch_limit_config, nvm_buck_one;
    logic [5:0] buck_one_code;
    logic [1:0] undervoltage_lockout_threshold, switch_three_current_limit;
    logic [1:0] switch_two_current_limit;
    logic [2:0] switch_enable, switch_on, switch_discharge;
    int error_cnt = 0;
    int num_checks = 0;
    int blank_cnt = 0;
    int pgd[4] = '{5, 8, 12, 16};

    host_model host (.ref_clk, .rd_data, .wr_en, .rd_en, .sub_addr, .wr_data);
    pmic_config_register_bank #(.HOLD_SHORT(40), .HOLD_LONG(60), .BLANK(20), .PGDLY0(5),
        .PGDLY1(8), .PGDLY2(12), .PGDLY3(16)) dut (
        .ref_clk, .reset, .wr_en, .rd_en, .sub_addr, .wr_data, .rd_data, .nvm_valid,
        .nvm_reset_pin_powergood_undervoltage_lockout_threshold_config, .nvm_supervisor_and_loadswitch_limit_config, .nvm_buck_one, .button_pressed, .button_reset,
        .rails_good, .power_good, .monitor_blank, .buck_one_code, .buck_one_pfm,
        .apply_no_discharge, .supervisor_tight_limits, .overvoltage_monitor_en,
        .undervoltage_lockout_threshold, .lockout_hysteresis_sel, .switch_three_current_limit,
        .switch_two_current_limit, .powerfail_comparator_out, .switch_enable, .switch_on,
        .switch_discharge, .first_out_ctrl, .second_out_ctrl, .third_out_ctrl,
        .first_io_pin_in, .first_io_pin_out, .first_io_pin_oe, .second_output_pin_out,
        .second_output_pin_oe, .third_io_pin_in, .third_io_pin_out, .third_io_pin_oe,
        .warm_reset_req);

    initial ref_clk = 1'b0;
    always #20 ref_clk = ~ref_clk;

    // Counted mid-cycle, so the write cycle that starts the blanking is seen too.
    always @(negedge ref_clk) begin
        if (monitor_blank === 1'b1) begin
            blank_cnt++;
        end
    end

    // ====================
    // Helpers
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.rd(a, d);
        chk(nm, d, exp);
    endtask : rchk

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc

    task automatic do_reset(input logic nv);
        nvm_valid = nv;
        reset = 1'b1;
        cyc(3);
        reset = 1'b0;
    endtask : do_reset

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results

    // ====================
    // Scenarios
    task automatic t_reset_and_lock;
        rchk("cfg1", `CFG1_OFS, 8'h08);
        rchk("cfg2", `CFG2_OFS, 8'h40);
        rchk("cfg3", `CFG3_OFS, 8'h00);
        rchk("buck", `BUCK1_OFS, 8'h80);
        chk("hys", lockout_hysteresis_sel, 1'b1);
        host.wr(`CFG2_OFS, 8'h00);
        rchk("locked", `CFG2_OFS, 8'h40);
        host.pwr(`CFG2_OFS, 8'hff);
        rchk("cfg2 rsvd", `CFG2_OFS, 8'hcf);
        host.pwr(`CFG3_OFS, 8'hff);
        rchk("cfg3 rsvd", `CFG3_OFS, 8'h3f);
        rchk("pwd", `PWD_OFS, 8'h00);
        rchk("unmapped", 8'h30, 8'h00);
        for (int k = 0; k < 4; k++) begin
            host.pwr(`CFG2_OFS, {4'h4, k[1:0], 2'(3 - k)});
            cyc(1);
            chk("ilim3", switch_three_current_limit, k);
            chk("ilim2", switch_two_current_limit, 3 - k);
        end
        $display("reset and lock done");
    endtask : t_reset_and_lock

    task automatic t_buck;
        blank_cnt = 0;
        host.pwr(`BUCK1_OFS, 8'h25);
        cyc(40);
        chk("blank cycles", blank_cnt, 20);
        chk("code held", buck_one_code, 6'h00);
        rchk("buck rd", `BUCK1_OFS, 8'h25);
        host.apply(1'b0);
        cyc(2);
        chk("code go", buck_one_code, 6'h25);
        chk("nodis go", apply_no_discharge, 1'b0);
        host.pwr(`BUCK1_OFS, 8'hff);
        rchk("buck rsvd", `BUCK1_OFS, 8'hbf);
        host.apply(1'b1);
        cyc(2);
        chk("code nodis", buck_one_code, 6'h3f);
        chk("nodis", apply_no_discharge, 1'b1);
        chk("pfm", buck_one_pfm, 1'b1);
        host.wr(`BUCK1_OFS, 8'h11);
        rchk("buck locked", `BUCK1_OFS, 8'hbf);
        $display("buck done");
    endtask : t_buck

    task automatic t_powergood;
        int n;
        for (int k = 0; k < 4; k++) begin
            host.pwr(`CFG1_OFS, {3'b000, k[1:0], k[0], k[1:0]});
            cyc(1);
            chk("undervoltage_lockout_threshold", undervoltage_lockout_threshold, k);
            chk("tight", supervisor_tight_limits, k[0]);
            chk("ov", overvoltage_monitor_en, k[0]);
            rails_good = 1'b1;
            n = 0;
            while (power_good !== 1'b1 && n < 100) begin
                cyc(1);
                n++;
            end
            chk("pg delay", n >= pgd[k] && n <= pgd[k] + 3, 1'b1);
            rails_good = 1'b0;
            cyc(2);
            chk("pg fall", power_good, 1'b0);
        end
        $display("power good done");
    endtask : t_powergood

    task automatic t_button;
        int n;
        int hold;
        for (int t = 0; t < 2; t++) begin
            hold = t ? 60 : 40;
            host.pwr(`CFG1_OFS, {t[0], 7'h08});
            button_pressed = 1'b1;
            n = 0;
            while (button_reset !== 1'b1 && n < 200) begin
                cyc(1);
                n++;
            end
            chk("hold", n >= hold - 1 && n <= hold + 2, 1'b1);
            cyc(1);
            n = 0;
            repeat (30) begin
                if (button_reset !== 1'b0) n++;
                cyc(1);
            end
            chk("one pulse", n, 0);
            button_pressed = 1'b0;
            cyc(2);
        end
        $display("button done");
    endtask : t_button

    task automatic t_switches;
        host.pwr(`CFG3_OFS, 8'h3f);
        switch_enable = 3'h5;
        powerfail_comparator_out = 1'b0;
        cyc(2);
        chk("pf off", switch_on, 3'h0);
        chk("dis on", switch_discharge, 3'h7);
        powerfail_comparator_out = 1'b1;
        cyc(2);
        chk("pf ok", switch_on, 3'h5);
        chk("dis idle", switch_discharge, 3'h2);
        host.pwr(`CFG3_OFS, 8'h00);
        powerfail_comparator_out = 1'b0;
        cyc(2);
        chk("pf ignored", switch_on, 3'h5);
        switch_enable = 3'h0;
        cyc(2);
        chk("dis off", switch_discharge, 3'h0);
        $display("switches done");
    endtask : t_switches

    task automatic t_pins;
        host.pwr(`CFG1_OFS, 8'h68);
        first_io_pin_in = 1'b0;
        cyc(2);
        chk("pp low", {second_output_pin_oe, second_output_pin_out}, 2'b10);
        chk("io1 input", first_io_pin_oe, 1'b0);
        first_io_pin_in = 1'b1;
        cyc(2);
        chk("pp high", {second_output_pin_oe, second_output_pin_out}, 2'b11);
        host.pwr(`CFG1_OFS, 8'h28);
        cyc(2);
        chk("od high", second_output_pin_oe, 1'b0);
        host.pwr(`CFG1_OFS, 8'h08);
        first_out_ctrl = 1'b0;
        second_out_ctrl = 1'b1;
        first_io_pin_in = 1'b0;
        cyc(2);
        chk("io1 low", {first_io_pin_oe, first_io_pin_out}, 2'b10);
        chk("second_output_pin free", second_output_pin_oe, 1'b0);
        second_out_ctrl = 1'b0;
        cyc(2);
        chk("second_output_pin low", {second_output_pin_oe, second_output_pin_out}, 2'b10);
        host.pwr(`CFG2_OFS, 8'hc0);
        third_out_ctrl = 1'b0;
        third_io_pin_in = 1'b0;
        cyc(2);
        chk("warm in", third_io_pin_oe, 1'b0);
        chk("warm req", warm_reset_req, 1'b1);
        third_io_pin_in = 1'b1;
        cyc(2);
        chk("warm idle", warm_reset_req, 1'b0);
        host.pwr(`CFG2_OFS, 8'h40);
        cyc(2);
        chk("gpo3 low", {third_io_pin_oe, third_io_pin_out}, 2'b10);
        $display("pins done");
    endtask : t_pins

    task automatic t_nvm;
        nvm_reset_pin_powergood_undervoltage_lockout_threshold_config = 8'ha5;
        nvm_supervisor_and_loadswitch_limit_config = 8'h80;
        nvm_buck_one = 8'h15;
        do_reset(1'b1);
        rchk("nvm cfg1", `CFG1_OFS, 8'ha5);
        rchk("nvm cfg2", `CFG2_OFS, 8'h80);
        rchk("nvm cfg3", `CFG3_OFS, 8'h00);
        rchk("nvm buck", `BUCK1_OFS, 8'h95);
        chk("nvm code", buck_one_code, 6'h15);
        $display("nvm done");
    endtask : t_nvm

    // ====================
    // Main sequence and watchdog
    initial begin
        {button_pressed, rails_good, first_io_pin_in, third_io_pin_in} = 4'h3;
        {first_out_ctrl, second_out_ctrl, third_out_ctrl} = 3'h7;
        powerfail_comparator_out = 1'b1;
        switch_enable = 3'h0;
        nvm_reset_pin_powergood_undervoltage_lockout_threshold_config = 8'h00;
        nvm_supervisor_and_loadswitch_limit_config = 8'h00;
        nvm_buck_one = 8'h00;
        do_reset(1'b0);
        t_reset_and_lock();
        t_buck();
        t_powergood();
        t_button();
        t_switches();
        t_pins();
        t_nvm();
        results();
    end

    // The full run takes a few hundred cycles; this span leaves ample margin.
    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        results();
    end
endmodule : pmic_config_register_bank_tb_top

//--- pmic_pkg.sv
// Types shared by the configuration bank and its timers.
// Assumes nothing of its surroundings.
package pmic_pkg;
    typedef enum logic [1:0] {
        PG_LOW = 2'b00,
        PG_WAIT = 2'b01,
        PG_HIGH = 2'b10
    } pg_state_t;
    typedef logic [31:0] count_t;
endpackage : pmic_pkg

//--- timer_if.sv
// Carrier between the bank and a down-counting timer.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface timer_if;
    import pmic_pkg::*;
    logic start;
    count_t count;
    logic busy;
    modport owner (output start, output count, input busy);
    modport timer (input start, input count, output busy);
endinterface : timer_if
